/* arsm_defs.svh */
// constants for the autoreclose supervisory state machine
// assumes a 100 MHz clock and a 1 ms time-base tick derived inside the block
`ifndef ARSM_DEFS_SVH
`define ARSM_DEFS_SVH
`define ARSM_CLK_HZ 100000000
`define ARSM_TICK_US 1000
`define ARSM_TICK_CYCLES ((`ARSM_CLK_HZ / 1000000) * `ARSM_TICK_US)
`define ARSM_BKR_SUP_MS 200
`define ARSM_TMR_W 16
`define ARSM_SHOT_W 3
`define ARSM_RATE_W 8
`define ARSM_HOUR_MS 3600000
`endif

/* arsm_pkg.sv */
// types of the autoreclose supervisory state machine
// assumes arsm_defs.svh is not needed here; only enumerations live in this package
`default_nettype none
package arsm_pkg;
   // one-hot states, top level and run substates flattened
   typedef enum logic [10:0] {
      ARSM_STANDBY  = 11'h001,
      ARSM_MCB_WAIT = 11'h002,
      ARSM_READY    = 11'h004,
      ARSM_BLOCKED  = 11'h008,
      ARSM_LOCKOUT  = 11'h010,
      ARSM_RUN      = 11'h020,
      ARSM_WAIT_OPN = 11'h040,
      ARSM_DEAD     = 11'h080,
      ARSM_RECLOSE  = 11'h100,
      ARSM_R2R      = 11'h200,
      ARSM_LO_RST   = 11'h400
   } arsm_state_t;
endpackage
`default_nettype wire

/* arsm_tick.sv */
// time-base divider: one-cycle pulse every tick period
// assumes a single free-running clock
`timescale 1ns/1ps
`default_nettype none
`include "arsm_defs.svh"
module arsm_tick #(
   parameter int TICK_CYCLES = `ARSM_TICK_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // tick
   output logic tick
);
   logic [31:0] cnt_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 32'h0000_0000;
         tick <= 1'b0;
      end else if (cnt_q == 32'(TICK_CYCLES - 1)) begin
         cnt_q <= 32'h0000_0000;
         tick <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 32'h0000_0001;
         tick <= 1'b0;
      end
   end
endmodule // arsm_tick
`default_nettype wire

/* arsm_sync.sv */
// three-flop synchroniser with agreement filter, one per input bit
// assumes inputs are asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module arsm_sync #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // data
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1_q, s2_q, s3_q;
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               s1_q[i] <= 1'b0;
               s2_q[i] <= 1'b0;
               s3_q[i] <= 1'b0;
               dout[i] <= 1'b0;
            end else begin
               s1_q[i] <= din[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               // a change counts once second and third agree
               if (s2_q[i] == s3_q[i]) begin
                  dout[i] <= s3_q[i];
               end
            end
         end
      end
   endgenerate
endmodule // arsm_sync
`default_nettype wire

/* arsm_top.sv */
// autoreclose supervisory state machine, top level
// assumes asynchronous pins for breaker and protection inputs, static settings ports
`timescale 1ns/1ps
`default_nettype none
`include "arsm_defs.svh"
module arsm_top #(
   parameter int TICK_CYCLES = `ARSM_TICK_CYCLES,
   parameter int SHOTS = 4,
   parameter int HOUR_TICKS = `ARSM_HOUR_MS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // configuration
   input wire logic func_enable,
   input wire logic breaker_assigned,
   input wire logic breaker_ready_used,
   input wire logic [`ARSM_SHOT_W-1:0] max_shots,
   input wire logic [`ARSM_RATE_W-1:0] reclose_rate_limit,
   input wire logic [`ARSM_TMR_W-1:0] manual_close_block_wait,
   input wire logic [`ARSM_TMR_W-1:0] fault_time,
   input wire logic [`ARSM_TMR_W-1:0] reclose_sup_time,
   input wire logic [`ARSM_TMR_W-1:0] run_to_ready_time,
   input wire logic [`ARSM_TMR_W-1:0] lockout_reset_time,
   input wire logic [SHOTS*`ARSM_TMR_W-1:0] dead_time,
   // pins from breaker and protection
   input wire logic breaker_closed,
   input wire logic breaker_ready,
   input wire logic initiate_pickup,
   input wire logic initiate_trip,
   input wire logic general_trip,
   input wire logic [1:0] external_block_inputs,
   input wire logic internal_block,
   input wire logic lockout_reset,
   input wire logic [1:0] service_alarm,
   // outputs
   output logic reclose_cmd,
   output logic [`ARSM_SHOT_W-1:0] shot_count,
   output arsm_pkg::arsm_state_t state,
   output logic success_flag,
   output logic failure_flag,
   output logic lockout_active
);
   // ------------------------------------------------------------
   // input conditioning
   // ------------------------------------------------------------
   localparam int NIN = 9;
   logic [NIN-1:0] raw_in, syn_in;
   assign raw_in = {breaker_closed, breaker_ready, initiate_pickup, initiate_trip,
                    general_trip, external_block_inputs, internal_block, lockout_reset};
   arsm_sync #(.W(NIN)) u_sync (
      .clk(clk),
      .rstn(rstn),
      .din(raw_in),
      .dout(syn_in)
   );
   logic cb_closed, cb_ready, ini_pu, ini_trip, gen_trip, int_blk, lo_rst;
   logic [1:0] ext_blk;
   assign cb_closed = syn_in[8];
   assign cb_ready = syn_in[7];
   assign ini_pu = syn_in[6];
   assign ini_trip = syn_in[5];
   assign gen_trip = syn_in[4];
   assign ext_blk = syn_in[3:2];
   assign int_blk = syn_in[1];
   assign lo_rst = syn_in[0];
   // service alarms are indication only, deliberately unused here
   logic unused_alarm;
   assign unused_alarm = ^service_alarm;

   // ------------------------------------------------------------
   // time base
   // ------------------------------------------------------------
   logic tick;
   arsm_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .clk(clk),
      .rstn(rstn),
      .tick(tick)
   );

   // ------------------------------------------------------------
   // qualifiers
   // ------------------------------------------------------------
   logic active, blocking, cb_closed_q, cb_close_evt, initiating, cb_ok;
   assign active = func_enable && breaker_assigned;
   assign blocking = active && ((|ext_blk) || int_blk);
   assign initiating = ini_pu || ini_trip;
   assign cb_ok = !breaker_ready_used || cb_ready;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cb_closed_q <= 1'b0;
      end else begin
         cb_closed_q <= cb_closed;
      end
   end
   assign cb_close_evt = cb_closed && !cb_closed_q;

   // ------------------------------------------------------------
   // state timer and transitions
   // ------------------------------------------------------------
   arsm_pkg::arsm_state_t st_q, st_d;
   logic [`ARSM_TMR_W-1:0] tmr_q, tmr_d;
   logic [`ARSM_SHOT_W-1:0] shot_q, shot_d;
   logic tmr_done, lo_cause, rate_over, recl_d, succ_evt, fail_evt;
   logic [`ARSM_TMR_W-1:0] dead_sel;
   logic [`ARSM_RATE_W-1:0] cyc_q;
   logic [31:0] hour_q;
   localparam logic [`ARSM_TMR_W-1:0] BKR_SUP = `ARSM_TMR_W'(`ARSM_BKR_SUP_MS);
   localparam logic [`ARSM_TMR_W-1:0] TMR_ZERO = `ARSM_TMR_W'(0);

   assign tmr_done = (tmr_q == TMR_ZERO);
   assign rate_over = (cyc_q >= reclose_rate_limit);
   // shot 0 is the pre-shot with no dead timer; counter n picks slot n, the wait before shot n+1
   always_comb begin
      dead_sel = TMR_ZERO;
      for (int k = 0; k < SHOTS; k++) begin
         if (32'(shot_q) == k) begin
            dead_sel = dead_time[k*`ARSM_TMR_W +: `ARSM_TMR_W];
         end
      end
   end

   always_comb begin
      st_d = st_q;
      tmr_d = tmr_q;
      shot_d = shot_q;
      recl_d = 1'b0;
      succ_evt = 1'b0;
      fail_evt = 1'b0;
      lo_cause = 1'b0;
      if (tick && !tmr_done) begin
         tmr_d = tmr_q - `ARSM_TMR_W'(1);
      end
      unique case (st_q)
         arsm_pkg::ARSM_STANDBY: begin
            // no reclose is ever raised from here
            if (blocking) begin
               st_d = arsm_pkg::ARSM_BLOCKED;
            end else if (active && cb_close_evt) begin
               st_d = arsm_pkg::ARSM_MCB_WAIT;
               tmr_d = manual_close_block_wait;
            end
         end
         arsm_pkg::ARSM_MCB_WAIT: begin
            if (blocking) begin
               st_d = arsm_pkg::ARSM_BLOCKED;
            end else if (tmr_done) begin
               // breaker tripped meanwhile: fall back to standby, not lockout
               st_d = cb_closed ? arsm_pkg::ARSM_READY : arsm_pkg::ARSM_STANDBY;
            end
         end
         arsm_pkg::ARSM_READY: begin
            if (blocking) begin
               st_d = arsm_pkg::ARSM_BLOCKED;
            end else if (!active || !cb_closed) begin
               st_d = arsm_pkg::ARSM_STANDBY;
            end else if (initiating) begin
               if (rate_over) begin
                  st_d = arsm_pkg::ARSM_LOCKOUT;
               end else begin
                  st_d = arsm_pkg::ARSM_RUN;
                  tmr_d = fault_time;
                  shot_d = '0;
               end
            end
         end
         arsm_pkg::ARSM_BLOCKED: begin
            if (!blocking) begin
               st_d = cb_closed ? arsm_pkg::ARSM_READY : arsm_pkg::ARSM_STANDBY;
            end
         end
         arsm_pkg::ARSM_LOCKOUT: begin
            if (lo_rst) begin
               st_d = arsm_pkg::ARSM_LO_RST;
               tmr_d = lockout_reset_time;
            end
         end
         arsm_pkg::ARSM_LO_RST: begin
            if (tmr_done) begin
               st_d = cb_closed ? arsm_pkg::ARSM_READY : arsm_pkg::ARSM_STANDBY;
            end
         end
         arsm_pkg::ARSM_RUN: begin
            if (blocking) begin
               st_d = arsm_pkg::ARSM_BLOCKED;
            end else if (tmr_done) begin
               lo_cause = 1'b1;
            end else if (ini_trip) begin
               st_d = arsm_pkg::ARSM_WAIT_OPN;
               tmr_d = BKR_SUP;
            end
         end
         arsm_pkg::ARSM_WAIT_OPN: begin
            if (blocking) begin
               st_d = arsm_pkg::ARSM_BLOCKED;
            end else if (!cb_closed) begin
               st_d = arsm_pkg::ARSM_DEAD;
               tmr_d = dead_sel;
            end else if (tmr_done) begin
               lo_cause = 1'b1;
            end
         end
         arsm_pkg::ARSM_DEAD: begin
            if (blocking) begin
               st_d = arsm_pkg::ARSM_BLOCKED;
            end else if (cb_closed) begin
               lo_cause = 1'b1;
            end else if (tmr_done) begin
               if (!cb_ok || initiating || gen_trip) begin
                  lo_cause = 1'b1;
               end else begin
                  shot_d = shot_q + `ARSM_SHOT_W'(1);
                  recl_d = 1'b1;
                  st_d = arsm_pkg::ARSM_RECLOSE;
                  tmr_d = reclose_sup_time;
               end
            end
         end
         arsm_pkg::ARSM_RECLOSE: begin
            if (blocking) begin
               st_d = arsm_pkg::ARSM_BLOCKED;
            end else if (cb_closed) begin
               st_d = arsm_pkg::ARSM_R2R;
               tmr_d = run_to_ready_time;
            end else if (tmr_done) begin
               lo_cause = 1'b1;
            end
         end
         arsm_pkg::ARSM_R2R: begin
            if (blocking) begin
               st_d = arsm_pkg::ARSM_BLOCKED;
            end else if (initiating) begin
               if (shot_q >= max_shots) begin
                  lo_cause = 1'b1;
                  fail_evt = 1'b1;
               end else begin
                  st_d = arsm_pkg::ARSM_RUN;
                  tmr_d = fault_time;
               end
            end else if (tmr_done) begin
               st_d = arsm_pkg::ARSM_READY;
               succ_evt = 1'b1;
            end
         end
         default: begin
            st_d = arsm_pkg::ARSM_STANDBY;
         end
      endcase
      if (lo_cause) begin
         st_d = arsm_pkg::ARSM_LOCKOUT;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= arsm_pkg::ARSM_STANDBY;
         tmr_q <= TMR_ZERO;
         shot_q <= '0;
      end else begin
         st_q <= st_d;
         tmr_q <= tmr_d;
         shot_q <= shot_d;
      end
   end

   // ------------------------------------------------------------
   // hourly cycle limit
   // ------------------------------------------------------------
   // fixed hour window, not sliding: cheaper, may admit up to twice the limit
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hour_q <= 32'h0000_0000;
         cyc_q <= '0;
      end else if (tick && hour_q == 32'(HOUR_TICKS - 1)) begin
         hour_q <= 32'h0000_0000;
         // a cycle ending on the window edge still counts, in the new window
         cyc_q <= (succ_evt || fail_evt) ? `ARSM_RATE_W'(1) : '0;
      end else begin
         if (tick) begin
            hour_q <= hour_q + 32'h0000_0001;
         end
         if ((succ_evt || fail_evt) && cyc_q != '1) begin
            cyc_q <= cyc_q + `ARSM_RATE_W'(1);
         end
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reclose_cmd <= 1'b0;
         shot_count <= '0;
         state <= arsm_pkg::ARSM_STANDBY;
         lockout_active <= 1'b0;
      end else begin
         reclose_cmd <= recl_d && (st_q != arsm_pkg::ARSM_STANDBY);
         shot_count <= shot_d;
         state <= st_d;
         lockout_active <= (st_d == arsm_pkg::ARSM_LOCKOUT) ||
                           (st_d == arsm_pkg::ARSM_LO_RST);
      end
   end

   // flags stick until the next cycle start
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         success_flag <= 1'b0;
         failure_flag <= 1'b0;
      end else if (succ_evt) begin
         success_flag <= 1'b1;
         failure_flag <= 1'b0;
      end else if (fail_evt) begin
         failure_flag <= 1'b1;
         success_flag <= 1'b0;
      end else if (st_q == arsm_pkg::ARSM_READY && st_d == arsm_pkg::ARSM_RUN) begin
         success_flag <= 1'b0;
         failure_flag <= 1'b0;
      end
   end
endmodule // arsm_top
`default_nettype wire

/* arsm_top_properties.sv */
// checker for the autoreclose state machine, bound to arsm_top
// assumes one clock, async active-low reset, one-hot state output
`timescale 1ns/1ps
`default_nettype none
`include "arsm_defs.svh"
module arsm_top_properties (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // watched inputs
   input wire logic func_enable,
   input wire logic [1:0] external_block_inputs,
   input wire logic internal_block,
   // watched outputs
   input wire logic reclose_cmd,
   input wire logic [`ARSM_SHOT_W-1:0] shot_count,
   input wire arsm_pkg::arsm_state_t state,
   input wire logic success_flag,
   input wire logic failure_flag,
   input wire logic lockout_active
);
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   chk_cmd_only_reclose: assert property (reclose_cmd |-> state == arsm_pkg::ARSM_RECLOSE)
      else $error("reclose command outside reclosing");
   chk_cmd_one_cycle: assert property (reclose_cmd |=> !reclose_cmd)
      else $error("reclose command longer than one cycle");
   chk_shot_before_cmd: assert property (reclose_cmd |-> shot_count != 3'h0)
      else $error("shot counter not advanced at reclose");
   chk_lockout_level: assert property (lockout_active == (state == arsm_pkg::ARSM_LOCKOUT
      || state == arsm_pkg::ARSM_LO_RST))
      else $error("lockout indication disagrees with state");
   chk_run_entry: assert property (state == arsm_pkg::ARSM_RUN
      && $past(state) != arsm_pkg::ARSM_RUN
      |-> $past(state) inside {arsm_pkg::ARSM_READY, arsm_pkg::ARSM_R2R})
      else $error("run entered from wrong state");
   chk_block_entry: assert property ($rose(|external_block_inputs || internal_block)
      && func_enable && !lockout_active |-> ##[1:10] state == arsm_pkg::ARSM_BLOCKED)
      else $error("block did not reach blocked state");
   chk_success_ready: assert property ($rose(success_flag) |-> state == arsm_pkg::ARSM_READY)
      else $error("success flag without return to ready");
   chk_failure_lock: assert property ($rose(failure_flag) |-> lockout_active)
      else $error("failure flag without lockout");
   chk_reclose_entry: assert property (state == arsm_pkg::ARSM_RECLOSE
      && $past(state) != arsm_pkg::ARSM_RECLOSE |-> $past(state) == arsm_pkg::ARSM_DEAD)
      else $error("reclosing entered from wrong state");
   chk_mcb_entry: assert property (state == arsm_pkg::ARSM_MCB_WAIT
      && $past(state) != arsm_pkg::ARSM_MCB_WAIT |-> $past(state) == arsm_pkg::ARSM_STANDBY)
      else $error("blocking wait entered from wrong state");
   chk_lockout_exit: assert property ($past(state) == arsm_pkg::ARSM_LOCKOUT
      && state != arsm_pkg::ARSM_LOCKOUT |-> state == arsm_pkg::ARSM_LO_RST)
      else $error("lockout left without reset phase");
endmodule // arsm_top_properties
bind arsm_top arsm_top_properties u_props (.clk(clk), .rstn(rstn), .func_enable(func_enable),
   .external_block_inputs(external_block_inputs), .internal_block(internal_block),
   .reclose_cmd(reclose_cmd), .shot_count(shot_count), .state(state),
   .success_flag(success_flag), .failure_flag(failure_flag), .lockout_active(lockout_active));
`default_nettype wire

/* arsm_breaker_model.sv */
// circuit breaker model: closes on command or manual request, opens on trip
// assumes requests are one-cycle pulses; operating time fixed by DLY
`timescale 1ns/1ps
`default_nettype none
module arsm_breaker_model #(
   parameter int DLY = 20
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // requests
   input wire logic reclose_cmd,
   input wire logic close_req,
   input wire logic open_req,
   // pins
   output logic breaker_closed,
   output logic breaker_ready
);
   // ---------------------------------------------------------------
   // mechanism
   // ---------------------------------------------------------------
   int cnt_q;
   logic tgt_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 0;
         tgt_q <= 1'b0;
         breaker_closed <= 1'b0;
      end else if (reclose_cmd || close_req) begin
         cnt_q <= DLY;
         tgt_q <= 1'b1;
      end else if (open_req) begin
         cnt_q <= DLY;
         tgt_q <= 1'b0;
      end else if (cnt_q > 0) begin
         cnt_q <= cnt_q - 1;
      end else begin
         breaker_closed <= tgt_q;
      end
   end
   // not ready while the mechanism moves, so a reclose mid-travel is refused
   assign breaker_ready = (cnt_q == 0);
endmodule // arsm_breaker_model
`default_nettype wire

/* arsm_top_tb.sv */
// testbench for arsm_top with a breaker model on the far side
// assumes short tick (10 cycles) and small timer settings in ticks
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module arsm_top_tb;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic en = 1'b0;
   logic [7:0] rl = 8'h0a;
   logic pick = 1'b0;
   logic trp = 1'b0;
   logic gtrip = 1'b0;
   logic [2:0] blk = 3'h0;
   logic lo_rst = 1'b0;
   logic [1:0] alarm = 2'h0;
   logic cl = 1'b0;
   logic op = 1'b0;
   logic asg = 1'b1;
   logic rdy_use = 1'b1;
   logic [2:0] mx = 3'h2;
   logic [63:0] dt = 64'h0009_0008_0007_0006;
   wire logic bkr_closed;
   wire logic bkr_ready;
   wire logic cmd;
   wire logic [2:0] shot;
   arsm_pkg::arsm_state_t state;
   wire logic succ;
   wire logic fail;
   wire logic lock;
   int mismatches = 0;
   int num_checks = 0;
   int n_cmd = 0;
   always #5 clk = ~clk;
   // counted mid-cycle, where the one-cycle pulse is settled
   always @(negedge clk) if (cmd === 1'b1) n_cmd++;
   arsm_top #(.TICK_CYCLES(10), .SHOTS(4), .HOUR_TICKS(5000)) DUT (.clk(clk), .rstn(rstn),
      .func_enable(en), .breaker_assigned(asg), .breaker_ready_used(rdy_use),
      .max_shots(mx), .reclose_rate_limit(rl), .manual_close_block_wait(16'h0003),
      .fault_time(16'h0014), .reclose_sup_time(16'h0014), .run_to_ready_time(16'h000a),
      .lockout_reset_time(16'h0003), .dead_time(dt),
      .breaker_closed(bkr_closed), .breaker_ready(bkr_ready), .initiate_pickup(pick),
      .initiate_trip(trp), .general_trip(gtrip), .external_block_inputs(blk[1:0]),
      .internal_block(blk[2]), .lockout_reset(lo_rst), .service_alarm(alarm),
      .reclose_cmd(cmd), .shot_count(shot), .state(state), .success_flag(succ),
      .failure_flag(fail), .lockout_active(lock));
   arsm_breaker_model #(.DLY(20)) u_bkr (.clk(clk), .rstn(rstn), .reclose_cmd(cmd),
      .close_req(cl), .open_req(op), .breaker_closed(bkr_closed), .breaker_ready(bkr_ready));
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic report_and_stop();
      if (mismatches == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // sampled on the falling edge, clear of the design's own updates
   task automatic wait_st(input arsm_pkg::arsm_state_t s, input int n);
      int i;
      i = 0;
      while (state !== s && i < n) begin
         @(negedge clk);
         i++;
      end
      `CHK("state", s, state)
   endtask
   task automatic bkr(input logic c);
      @(posedge clk);
      cl <= c;
      op <= ~c;
      @(posedge clk);
      cl <= 1'b0;
      op <= 1'b0;
   endtask
   task automatic shot_run(input logic [2:0] n);
      @(posedge clk);
      pick <= 1'b1;
      wait_st(arsm_pkg::ARSM_RUN, 50);
      `CHK("shot", n - 3'h1, shot)
      @(posedge clk);
      trp <= 1'b1;
      wait_st(arsm_pkg::ARSM_WAIT_OPN, 50);
      bkr(1'b0);
      wait_st(arsm_pkg::ARSM_DEAD, 60);
      @(posedge clk);
      pick <= 1'b0;
      trp <= 1'b0;
   endtask
   task automatic shot_cycle(input logic [2:0] n);
      shot_run(n);
      wait_st(arsm_pkg::ARSM_RECLOSE, 100);
      `CHK("shot", n, shot)
      wait_st(arsm_pkg::ARSM_R2R, 60);
   endtask
   task automatic lo_reset(input arsm_pkg::arsm_state_t fin);
      repeat (50) @(posedge clk);
      `CHK("hold", arsm_pkg::ARSM_LOCKOUT, state)
      `CHK("lock", 1'b1, lock)
      lo_rst <= 1'b1;
      wait_st(arsm_pkg::ARSM_LO_RST, 20);
      @(posedge clk);
      lo_rst <= 1'b0;
      wait_st(fin, 100);
   endtask
   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      `CHK("state", arsm_pkg::ARSM_STANDBY, state)
      bkr(1'b1);
      repeat (80) @(negedge clk);
      `CHK("state", arsm_pkg::ARSM_STANDBY, state)
      bkr(1'b0);
      repeat (40) @(posedge clk);
      en <= 1'b1;
      bkr(1'b1);
      wait_st(arsm_pkg::ARSM_MCB_WAIT, 60);
      wait_st(arsm_pkg::ARSM_READY, 100);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         blk <= 3'h1 << i;
         wait_st(arsm_pkg::ARSM_BLOCKED, 20);
         @(posedge clk);
         blk <= 3'h0;
         wait_st(arsm_pkg::ARSM_READY, 20);
      end
      @(posedge clk);
      alarm <= 2'h3;
      shot_cycle(3'h1);
      wait_st(arsm_pkg::ARSM_READY, 150);
      `CHK("succ", 1'b1, succ)
      `CHK("cmds", 1, n_cmd)
      @(posedge clk);
      alarm <= 2'h0;
      rl <= 8'h01;
      pick <= 1'b1;
      wait_st(arsm_pkg::ARSM_LOCKOUT, 50);
      @(posedge clk);
      pick <= 1'b0;
      rl <= 8'h0a;
      lo_reset(arsm_pkg::ARSM_READY);
      shot_cycle(3'h1);
      shot_cycle(3'h2);
      @(posedge clk);
      pick <= 1'b1;
      wait_st(arsm_pkg::ARSM_LOCKOUT, 50);
      `CHK("fail", 1'b1, fail)
      @(posedge clk);
      pick <= 1'b0;
      lo_reset(arsm_pkg::ARSM_READY);
      @(posedge clk);
      pick <= 1'b1;
      wait_st(arsm_pkg::ARSM_RUN, 50);
      wait_st(arsm_pkg::ARSM_LOCKOUT, 300);
      @(posedge clk);
      pick <= 1'b0;
      lo_reset(arsm_pkg::ARSM_READY);
      shot_run(3'h1);
      gtrip <= 1'b1;
      wait_st(arsm_pkg::ARSM_LOCKOUT, 100);
      `CHK("cmds", 3, n_cmd)
      @(posedge clk);
      gtrip <= 1'b0;
      lo_reset(arsm_pkg::ARSM_STANDBY);
      @(posedge clk);
      pick <= 1'b1;
      repeat (50) @(negedge clk);
      `CHK("state", arsm_pkg::ARSM_STANDBY, state)
      `CHK("cmds", 3, n_cmd)
      @(posedge clk);
      pick <= 1'b0;
      bkr(1'b1);
      wait_st(arsm_pkg::ARSM_MCB_WAIT, 60);
      wait_st(arsm_pkg::ARSM_READY, 100);
      @(posedge clk);
      asg <= 1'b0;
      wait_st(arsm_pkg::ARSM_STANDBY, 10);
      report_and_stop();
   end
   // run takes under 2000 cycles; the margin covers slow timer paths
   initial begin
      repeat (40000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end
endmodule // arsm_top_tb
`default_nettype wire
